// ### core/sfcs_sequencer.sv
// supervisory flash call sequencer with its data RAM, flash array and AXI4-Lite slave
// Operation
// - reset clears program counter to zero
// - each interrupt vectors to its four-byte slot
// - user space runs from 0x0068 to 0x1FFF
// - provide 256 bytes of data RAM
// - flash controls reachable only inside supervisory ROM
// - supervisory ROM is a separate address space
// - whole erase leaves auxiliary rows untouched
// - two pins enter serial programming mode
// - call enters ROM, dispatches on accumulator
// - function codes 00,01,02,03,05,06,07 decoded
// - undefined function from user code halts
// - key mismatch halts, boot reset exempt
// - parameter block sits at F8h to FFh
// - function writes return code to first key
// - return codes 00,01,02,03 as defined
// - checksum and table read return data instead
// - refuse operations that block protection forbids
// - erase all: erase, zeros, erase per macro
// - then erase and zero protection block
// - refusal clears accumulator, second key; code 01h
// - a block is 64 contiguous bytes
// - two-bit levels, four blocks per byte
`timescale 1ns/1ps
`default_nettype none
`include "sfcs_map.svh"
module sfcs_sequencer #(
   parameter logic [31:0] CAL_TABLE = 32'h5A5A_0F0F
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire sfcs_pkg::sfcs_axi_req_type axiReq,
   output sfcs_pkg::sfcs_axi_rsp_type axiRsp,
   input wire logic progPinA,
   input wire logic progPinB,
   input wire logic tqValid,
   input wire logic [7:0] tqFunc,
   input wire logic [7:0] tqSp,
   output logic tqReady,
   input wire logic irqTake,
   input wire logic [4:0] irqSource,
   output logic [15:0] progCounter,
   output logic romSpace,
   output logic cpuHalted,
   output logic ispMode,
   output logic seqBusy
);
   sfcs_pkg::sfcs_state_type st;
   sfcs_pkg::sfcs_state_type next_st;
   logic [7:0] ram [0:`SFCS_RAM_BYTES-1];
   logic [7:0] flash [0:`SFCS_FLASH_BYTES-1];
   logic [7:0] protRow [0:`SFCS_PROT_BYTES-1];
   logic ramWe;
   logic [7:0] ramWa;
   logic [7:0] ramWd;
   logic flashWe;
   logic [12:0] flashWa;
   logic [7:0] flashWd;
   logic protWe;
   logic [5:0] protWa;
   logic [7:0] protWd;
   logic [7:0] blk;
   logic [7:0] ptr;
   logic [7:0] protByte;
   logic [1:0] level;
   logic idle;
   logic isp;
   logic [12:0] blkAddr;
   logic [7:0] ramIdx;
   logic [7:0] rdIdx;

   // reads of the parameter block; only the fields the hardware acts on
   assign blk = ram[`SFCS_PAR_BLOCK];
   assign ptr = ram[`SFCS_PAR_POINTER];
   assign protByte = protRow[blk[7:2]];
   assign level = protByte[{blk[1:0], 1'b0} +: 2];
   assign blkAddr = {blk[6:0], st.idx[5:0]};
   assign ramIdx = 8'(ptr + {2'b00, st.idx[5:0]});
   assign idle = (st.fsm == sfcs_pkg::S_IDLE);
   assign isp = st.pinA[1] & st.pinB[1];
   assign rdIdx = axiReq.araddr[9:2];
   assign tqReady = idle & isp & ~st.halted;
   assign progCounter = st.pc;
   assign romSpace = st.inRom;
   assign cpuHalted = st.halted;
   assign ispMode = isp;
   assign seqBusy = ~idle;
   assign axiRsp.awready = ~st.awHeld;
   assign axiRsp.wready = ~st.wHeld;
   assign axiRsp.bvalid = st.bvalid;
   assign axiRsp.bresp = st.bresp;
   assign axiRsp.arready = ~st.rvalid;
   assign axiRsp.rvalid = st.rvalid;
   assign axiRsp.rdata = st.rdata;
   assign axiRsp.rresp = st.rresp;

   always_comb
   begin
      next_st = st;
      ramWe = 1'b0;
      ramWa = st.awAddr[9:2];
      ramWd = st.wData[7:0];
      flashWe = 1'b0;
      flashWa = blkAddr;
      flashWd = `SFCS_ERASED;
      protWe = 1'b0;
      protWa = st.wData[5:0];
      protWd = st.wData[15:8];
      next_st.pinA = {st.pinA[0], progPinA};
      next_st.pinB = {st.pinB[0], progPinB};
      if (irqTake && !st.inRom && !st.halted)
      begin
         next_st.pc = {9'h000, irqSource, 2'b00};
      end
      // bus write channel: address and data are caught in either order
      if (axiReq.awvalid && !st.awHeld)
      begin
         next_st.awHeld = 1'b1;
         next_st.awAddr = axiReq.awaddr[11:0];
      end
      if (axiReq.wvalid && !st.wHeld)
      begin
         next_st.wHeld = 1'b1;
         next_st.wData = axiReq.wdata;
      end
      if (st.bvalid && axiReq.bready)
      begin
         next_st.bvalid = 1'b0;
      end
      if (st.awHeld && st.wHeld && !st.bvalid)
      begin
         next_st.awHeld = 1'b0;
         next_st.wHeld = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = `SFCS_RESP_OKAY;
         if (st.awAddr[11:10] == `SFCS_RAM_WINDOW)
         begin
            // the sequencer owns the RAM port while a call runs
            if (idle)
               ramWe = 1'b1;
            else
               next_st.bresp = `SFCS_RESP_SLVERR;
         end
         else
         begin
            case (st.awAddr)
               `SFCS_REG_CTRL:
               begin
                  if (st.wData[`SFCS_START_BIT] && idle && !st.halted && !tqValid)
                  begin
                     next_st.acc = st.wData[7:0];
                     next_st.sp = st.wData[15:8];
                     next_st.func = st.wData[7:0];
                     next_st.fromIsp = 1'b0;
                     next_st.inRom = 1'b1;
                     next_st.fsm = sfcs_pkg::S_CHECK;
                  end
                  else if (st.wData[`SFCS_START_BIT])
                     next_st.bresp = `SFCS_RESP_SLVERR;
               end
               `SFCS_REG_PC:
                  if (!st.inRom && !st.halted)
                     next_st.pc = st.wData[15:0] & `SFCS_USER_END;
               `SFCS_REG_VECTOR:
                  if (!st.inRom && !st.halted)
                     next_st.pc = {9'h000, st.wData[4:0], 2'b00};
               `SFCS_REG_PROT:
               begin
                  // levels are set only while being programmed from outside
                  if (isp && idle)
                     protWe = 1'b1;
                  else
                     next_st.bresp = `SFCS_RESP_SLVERR;
               end
               `SFCS_REG_DIRECT:
               begin
                  if (st.inRom)
                     next_st.directAddr = st.wData[12:0];
                  else
                     next_st.bresp = `SFCS_RESP_SLVERR;
               end
               default:
                  next_st.bresp = `SFCS_RESP_DECERR;
            endcase
         end
      end
      // bus read channel: answer one cycle after the address is taken
      if (st.rvalid && axiReq.rready)
      begin
         next_st.rvalid = 1'b0;
      end
      if (axiReq.arvalid && !st.rvalid)
      begin
         next_st.rvalid = 1'b1;
         next_st.rresp = `SFCS_RESP_OKAY;
         next_st.rdata = 32'h0000_0000;
         if (axiReq.araddr[11:10] == `SFCS_RAM_WINDOW)
            next_st.rdata = {24'h00_0000, ram[rdIdx]};
         else
         begin
            case (axiReq.araddr[11:0])
               `SFCS_REG_CTRL:
                  next_st.rdata = {16'h0000, st.sp, st.acc};
               `SFCS_REG_STATUS:
                  next_st.rdata = {8'h00, st.rcLow, 7'h00, st.fsm,
                     (st.pc >= `SFCS_USER_START), isp, st.inRom, st.halted, ~idle};
               `SFCS_REG_PC:
                  next_st.rdata = {16'h0000, st.pc};
               `SFCS_REG_PROT:
                  next_st.rdata = {24'h00_0000, protRow[axiReq.araddr[17:12]]};
               `SFCS_REG_DIRECT:
               begin
                  if (st.inRom)
                     next_st.rdata = {24'h00_0000, flash[st.directAddr]};
                  else
                     next_st.rresp = `SFCS_RESP_SLVERR;
               end
               default:
                  next_st.rresp = `SFCS_RESP_DECERR;
            endcase
         end
      end
      // call sequencer
      case (st.fsm)
         sfcs_pkg::S_IDLE:
         begin
            if (tqValid && tqReady)
            begin
               next_st.acc = tqFunc;
               next_st.sp = tqSp;
               next_st.func = tqFunc;
               next_st.fromIsp = 1'b1;
               next_st.inRom = 1'b1;
               next_st.fsm = sfcs_pkg::S_CHECK;
            end
         end
         sfcs_pkg::S_CHECK:
         begin
            next_st.idx = 13'h0000;
            next_st.sum = 16'h0000;
            next_st.rcLow = `SFCS_RC_OK;
            next_st.rcHigh = `SFCS_ZERO;
            if (st.func == `SFCS_FN_BOOT)
            begin
               // boot reset ignores keys and parameters
               next_st.pc = `SFCS_PC_RESET;
               next_st.inRom = 1'b0;
               next_st.fsm = sfcs_pkg::S_IDLE;
            end
            else if (!(st.func inside {`SFCS_FN_READ, `SFCS_FN_WRITE, `SFCS_FN_ERASE,
               `SFCS_FN_ALL, `SFCS_FN_TABLE, `SFCS_FN_CSUM}))
            begin
               if (st.fromIsp)
               begin
                  next_st.rcLow = `SFCS_RC_FATAL;
                  next_st.fsm = sfcs_pkg::S_RET_LOW;
               end
               else
                  next_st.fsm = sfcs_pkg::S_HALT;
            end
            else if (ram[`SFCS_PAR_FIRST_KEY] != `SFCS_FIRST_KEY_VALUE ||
               ram[`SFCS_PAR_SECOND_KEY] != 8'(st.sp + `SFCS_SECOND_KEY_OFFSET))
               next_st.fsm = sfcs_pkg::S_HALT;
            else if ((st.func == `SFCS_FN_READ && level == `SFCS_PROT_READ) ||
               ((st.func == `SFCS_FN_WRITE || st.func == `SFCS_FN_ERASE) &&
               (st.fromIsp ? level[1] : (level == `SFCS_PROT_INT))))
            begin
               next_st.acc = `SFCS_ZERO;
               next_st.rcLow = `SFCS_RC_PROT;
               next_st.fsm = sfcs_pkg::S_RET_LOW;
            end
            else
            begin
               case (st.func)
                  `SFCS_FN_READ: next_st.fsm = sfcs_pkg::S_READ;
                  `SFCS_FN_WRITE: next_st.fsm = sfcs_pkg::S_WRITE;
                  `SFCS_FN_ERASE: next_st.fsm = sfcs_pkg::S_ERASE;
                  `SFCS_FN_ALL: next_st.fsm = sfcs_pkg::S_ALL_ERASE1;
                  `SFCS_FN_CSUM: next_st.fsm = sfcs_pkg::S_CSUM;
                  default:
                  begin
                     // table data replaces the return code
                     next_st.rcLow = CAL_TABLE[{blk[1:0], 3'b000} +: 8];
                     next_st.fsm = sfcs_pkg::S_RET_LOW;
                  end
               endcase
            end
         end
         sfcs_pkg::S_READ, sfcs_pkg::S_WRITE, sfcs_pkg::S_ERASE:
         begin
            if (st.fsm == sfcs_pkg::S_READ)
            begin
               ramWe = 1'b1;
               ramWa = ramIdx;
               ramWd = flash[blkAddr];
            end
            else
            begin
               flashWe = 1'b1;
               flashWd = (st.fsm == sfcs_pkg::S_WRITE) ? ram[ramIdx] : `SFCS_ERASED;
            end
            next_st.idx = 13'(st.idx + 13'h0001);
            if (st.idx[5:0] == `SFCS_BLOCK_LAST)
               next_st.fsm = sfcs_pkg::S_RET_LOW;
         end
         sfcs_pkg::S_ALL_ERASE1, sfcs_pkg::S_ALL_ZERO, sfcs_pkg::S_ALL_ERASE2:
         begin
            // a single macro here; auxiliary rows live apart and stay as they are
            flashWe = 1'b1;
            flashWa = st.idx;
            flashWd = (st.fsm == sfcs_pkg::S_ALL_ZERO) ? `SFCS_ZERO : `SFCS_ERASED;
            next_st.idx = 13'(st.idx + 13'h0001);
            if (st.idx == `SFCS_FLASH_LAST)
            begin
               case (st.fsm)
                  sfcs_pkg::S_ALL_ERASE1: next_st.fsm = sfcs_pkg::S_ALL_ZERO;
                  sfcs_pkg::S_ALL_ZERO: next_st.fsm = sfcs_pkg::S_ALL_ERASE2;
                  default: next_st.fsm = sfcs_pkg::S_PROT_ERASE;
               endcase
            end
         end
         sfcs_pkg::S_PROT_ERASE, sfcs_pkg::S_PROT_ZERO:
         begin
            protWe = 1'b1;
            protWa = st.idx[5:0];
            protWd = (st.fsm == sfcs_pkg::S_PROT_ZERO) ? `SFCS_ZERO : `SFCS_ERASED;
            next_st.idx = 13'(st.idx + 13'h0001);
            if (st.idx[5:0] == `SFCS_BLOCK_LAST)
            begin
               next_st.idx = 13'h0000;
               if (st.fsm == sfcs_pkg::S_PROT_ERASE)
                  next_st.fsm = sfcs_pkg::S_PROT_ZERO;
               else
                  next_st.fsm = sfcs_pkg::S_RET_LOW;
            end
         end
         sfcs_pkg::S_CSUM:
         begin
            next_st.sum = st.sum + {8'h00, flash[st.idx]};
            next_st.idx = 13'(st.idx + 13'h0001);
            if (st.idx == {blk[6:0], `SFCS_BLOCK_LAST})
            begin
               next_st.rcLow = next_st.sum[7:0];
               next_st.rcHigh = next_st.sum[15:8];
               next_st.fsm = sfcs_pkg::S_RET_LOW;
            end
         end
         sfcs_pkg::S_RET_LOW:
         begin
            ramWe = 1'b1;
            ramWa = `SFCS_PAR_FIRST_KEY;
            ramWd = st.rcLow;
            next_st.fsm = sfcs_pkg::S_RET_HIGH;
         end
         sfcs_pkg::S_RET_HIGH:
         begin
            ramWe = 1'b1;
            ramWa = `SFCS_PAR_SECOND_KEY;
            ramWd = st.rcHigh;
            next_st.acc = `SFCS_ZERO;
            next_st.inRom = 1'b0;
            next_st.fsm = sfcs_pkg::S_IDLE;
         end
         sfcs_pkg::S_HALT:
         begin
            next_st.halted = 1'b1;
            next_st.inRom = 1'b0;
         end
         default:
            next_st.fsm = sfcs_pkg::S_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         st <= sfcs_pkg::sfcs_state_type'(0);
      else
         st <= next_st;
   end

   // memories carry no reset; only protection levels start known
   always_ff @(posedge ref_clk)
   begin
      if (ramWe)
         ram[ramWa] <= ramWd;
      if (flashWe)
         flash[flashWa] <= flashWd;
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         for (int i = 0; i < `SFCS_PROT_BYTES; i++)
            protRow[i] <= `SFCS_ZERO;
      end
      else if (protWe)
         protRow[protWa] <= protWd;
   end
endmodule : sfcs_sequencer
`default_nettype wire

// ### core/sfcs_map.svh
// address map, codes and reset values of the supervisory flash call sequencer
`ifndef SFCS_MAP_SVH
`define SFCS_MAP_SVH
`define SFCS_PC_RESET 16'h0000
`define SFCS_VEC_ONE_MS 16'h0034
`define SFCS_VEC_TIMER_WRAP 16'h0044
`define SFCS_VEC_SLEEP 16'h0064
`define SFCS_USER_START 16'h0068
`define SFCS_USER_END 16'h1FFF
`define SFCS_RAM_BYTES 256
`define SFCS_FLASH_BYTES 8192
`define SFCS_PROT_BYTES 64
`define SFCS_BLOCK_LAST 6'h3F
`define SFCS_FLASH_LAST 13'h1FFF
`define SFCS_ERASED 8'hFF
`define SFCS_ZERO 8'h00
`define SFCS_FIRST_KEY_VALUE 8'h3A
`define SFCS_SECOND_KEY_OFFSET 8'h03
`define SFCS_PAR_FIRST_KEY 8'hF8
`define SFCS_PAR_SECOND_KEY 8'hF9
`define SFCS_PAR_BLOCK 8'hFA
`define SFCS_PAR_POINTER 8'hFB
`define SFCS_PAR_CLOCK 8'hFC
`define SFCS_PAR_MODE 8'hFD
`define SFCS_PAR_DELAY 8'hFE
`define SFCS_PAR_PCL 8'hFF
`define SFCS_FN_BOOT 8'h00
`define SFCS_FN_READ 8'h01
`define SFCS_FN_WRITE 8'h02
`define SFCS_FN_ERASE 8'h03
`define SFCS_FN_ALL 8'h05
`define SFCS_FN_TABLE 8'h06
`define SFCS_FN_CSUM 8'h07
`define SFCS_RC_OK 8'h00
`define SFCS_RC_PROT 8'h01
`define SFCS_RC_SWRESET 8'h02
`define SFCS_RC_FATAL 8'h03
`define SFCS_PROT_READ 2'b01
`define SFCS_PROT_EXT 2'b10
`define SFCS_PROT_INT 2'b11
`define SFCS_REG_CTRL 12'h000
`define SFCS_REG_STATUS 12'h004
`define SFCS_REG_PC 12'h008
`define SFCS_REG_VECTOR 12'h00C
`define SFCS_REG_PROT 12'h010
`define SFCS_REG_DIRECT 12'h014
`define SFCS_RAM_WINDOW 2'b01
`define SFCS_START_BIT 31
`define SFCS_RESP_OKAY 2'b00
`define SFCS_RESP_SLVERR 2'b10
`define SFCS_RESP_DECERR 2'b11
`endif

// ### core/sfcs_pkg.sv
// types of the supervisory flash call sequencer
package sfcs_pkg;
   typedef enum logic [3:0] {S_IDLE, S_CHECK, S_READ, S_WRITE, S_ERASE, S_ALL_ERASE1,
      S_ALL_ZERO, S_ALL_ERASE2, S_PROT_ERASE, S_PROT_ZERO, S_CSUM, S_RET_LOW,
      S_RET_HIGH, S_HALT} sfcs_fsm_type;
   typedef struct packed {
      logic awvalid;
      logic [31:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [31:0] araddr;
      logic rready;
   } sfcs_axi_req_type;
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } sfcs_axi_rsp_type;
   typedef struct packed {
      sfcs_fsm_type fsm;
      logic [15:0] pc;
      logic [7:0] acc;
      logic [7:0] sp;
      logic [7:0] func;
      logic fromIsp;
      logic halted;
      logic inRom;
      logic [12:0] idx;
      logic [15:0] sum;
      logic [7:0] rcLow;
      logic [7:0] rcHigh;
      logic [12:0] directAddr;
      logic awHeld;
      logic [11:0] awAddr;
      logic wHeld;
      logic [31:0] wData;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [1:0] pinA;
      logic [1:0] pinB;
   } sfcs_state_type;
endpackage : sfcs_pkg

// ### testbench/sfcs_checker.sv
// port assertions of the supervisory flash call sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sfcs_map.svh"
module sfcs_checker (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire sfcs_pkg::sfcs_axi_req_type axiReq,
   input wire sfcs_pkg::sfcs_axi_rsp_type axiRsp,
   input wire logic progPinA,
   input wire logic progPinB,
   input wire logic tqValid,
   input wire logic tqReady,
   input wire logic irqTake,
   input wire logic [4:0] irqSource,
   input wire logic [15:0] progCounter,
   input wire logic romSpace,
   input wire logic cpuHalted,
   input wire logic ispMode,
   input wire logic seqBusy
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);
   a_pc_reset_zero: assert property ($fell(sys_rst) |-> progCounter == `SFCS_PC_RESET)
      else $error("pc not zero after reset");
   a_vector_slot: assert property (irqTake && !romSpace && !cpuHalted |=>
      progCounter == {9'h000, $past(irqSource), 2'b00})
      else $error("irq missed its slot");
   a_halt_sticky: assert property (cpuHalted |=> cpuHalted)
      else $error("halt released");
   a_halt_pc_frozen: assert property (cpuHalted |=> $stable(progCounter))
      else $error("pc moved while halted");
   a_tq_ready_rule: assert property (tqReady == (!seqBusy && ispMode && !cpuHalted))
      else $error("tqReady wrong");
   a_isp_pin_entry: assert property ($rose(ispMode) |-> $past(progPinA, 2) && $past(progPinB, 2))
      else $error("isp mode without pins");
   a_rom_while_busy: assert property ($rose(romSpace) |-> seqBusy)
      else $error("rom entered while idle");
   a_direct_locked: assert property (axiReq.arvalid && axiRsp.arready &&
      axiReq.araddr == 32'h0000_0014 && !romSpace |-> ##[1:2]
      (axiRsp.rvalid && axiRsp.rresp == `SFCS_RESP_SLVERR))
      else $error("direct read outside rom");
   a_prot_locked: assert property (axiReq.awvalid && axiRsp.awready && axiReq.wvalid &&
      axiRsp.wready && axiReq.awaddr == 32'h0000_0010 && !ispMode |-> ##[1:2]
      (axiRsp.bvalid && axiRsp.bresp == `SFCS_RESP_SLVERR))
      else $error("prot write outside isp");
   c_halt: cover property ($rose(cpuHalted));
   c_call_done: cover property ($fell(seqBusy));
   c_tq_taken: cover property (tqValid && tqReady);
endmodule : sfcs_checker
bind sfcs_sequencer sfcs_checker u_sfcs_checker (.*);
`default_nettype wire

// ### testbench/sfcs_isp_model.sv
// in-system programmer model: mode pins and test-queue calls
`timescale 1ns/1ps
`default_nettype none
module sfcs_isp_model (
   input wire logic ref_clk,
   input wire logic tqReady,
   output logic progPinA,
   output logic progPinB,
   output logic tqValid,
   output logic [7:0] tqFunc,
   output logic [7:0] tqSp
);
   initial
   begin
      progPinA = 1'b0;
      progPinB = 1'b0;
      tqValid = 1'b0;
      tqFunc = 8'h00;
      tqSp = 8'h00;
   end
   task automatic pins(input logic on);
      @(posedge ref_clk);
      progPinA <= on;
      progPinB <= on;
   endtask : pins
   task automatic issue(input logic [7:0] fn, input logic [7:0] sp);
      logic took;
      @(posedge ref_clk);
      tqValid <= 1'b1;
      tqFunc <= fn;
      tqSp <= sp;
      do
      begin
         @(negedge ref_clk);
         took = tqReady;
         @(posedge ref_clk);
      end while (!took);
      tqValid <= 1'b0;
      // released fields must not keep showing the last code
      tqFunc <= ~fn;
      tqSp <= ~sp;
   endtask : issue
endmodule : sfcs_isp_model
`default_nettype wire

// ### testbench/tb.sv
// self-checking bench of the supervisory flash call sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sfcs_map.svh"
module tb;
   // arbitrary table contents, bytes chosen to differ
   localparam logic [31:0] CAL = 32'h1234_5678;
   localparam logic [7:0] SP = 8'h40;
   logic ref_clk, sys_rst, irqTake, progPinA, progPinB, tqValid, tqReady;
   logic romSpace, cpuHalted, ispMode, seqBusy;
   logic [4:0] irqSource;
   logic [7:0] tqFunc, tqSp;
   logic [15:0] progCounter, pcHeld;
   logic [31:0] d;
   logic [1:0] r;
   logic [4:0] slot [3] = '{5'h0D, 5'h11, 5'h19};
   logic [15:0] pcIn [3] = '{16'h0067, 16'h0068, 16'hFFFF};
   sfcs_pkg::sfcs_axi_req_type axiReq;
   sfcs_pkg::sfcs_axi_rsp_type axiRsp;
   int numErrors = 0;
   int nTests = 0;
   sfcs_sequencer #(.CAL_TABLE(CAL)) u_sfcs_sequencer (.*);
   sfcs_isp_model u_sfcs_isp_model (.*);
   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   task tally_and_finish;
      $display("checks %0d mismatches %0d", nTests, numErrors);
      if (numErrors == 0 && nTests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      nTests++;
      if (g !== e)
      begin
         numErrors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] rs);
      logic aw, w, b;
      @(posedge ref_clk);
      axiReq.awaddr <= a;
      axiReq.wdata <= v;
      axiReq.wstrb <= 4'hF;
      axiReq.awvalid <= 1'b1;
      axiReq.wvalid <= 1'b1;
      axiReq.bready <= 1'b1;
      do
      begin
         @(negedge ref_clk);
         aw = axiReq.awvalid & axiRsp.awready;
         w = axiReq.wvalid & axiRsp.wready;
         b = axiRsp.bvalid;
         rs = axiRsp.bresp;
         @(posedge ref_clk);
         if (aw)
            axiReq.awvalid <= 1'b0;
         if (w)
            axiReq.wvalid <= 1'b0;
      end while (!b);
      axiReq.bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rs);
      logic ar, ok;
      @(posedge ref_clk);
      axiReq.araddr <= a;
      axiReq.arvalid <= 1'b1;
      axiReq.rready <= 1'b1;
      do
      begin
         @(negedge ref_clk);
         ar = axiReq.arvalid & axiRsp.arready;
         ok = axiRsp.rvalid;
         v = axiRsp.rdata;
         rs = axiRsp.rresp;
         @(posedge ref_clk);
         if (ar)
            axiReq.arvalid <= 1'b0;
      end while (!ok);
      axiReq.rready <= 1'b0;
   endtask : rd
   function automatic logic [31:0] ra(input logic [7:0] n);
      return 32'h0000_0400 + {22'h0, n, 2'b00};
   endfunction : ra
   task automatic prm(input logic [7:0] blk, input logic [7:0] k1);
      wr(ra(8'hF8), {24'h0, k1}, r);
      wr(ra(8'hF9), {24'h0, SP + 8'h03}, r);
      wr(ra(8'hFA), {24'h0, blk}, r);
      wr(ra(8'hFB), 32'h0000_0000, r);
   endtask : prm
   // a halted call never goes idle, so the wait also ends on halt
   task automatic waitc();
      repeat (2) @(posedge ref_clk);
      while (seqBusy === 1'b1 && cpuHalted !== 1'b1)
         @(posedge ref_clk);
      @(negedge ref_clk);
   endtask : waitc
   task automatic call(input logic [7:0] fn, input logic [7:0] blk, input logic [7:0] k1);
      prm(blk, k1);
      wr(32'h0000_0000, {16'h8000, SP, fn}, r);
      waitc();
   endtask : call
   task automatic kk(input logic [7:0] e1, input logic [7:0] e2);
      rd(ra(8'hF8), d, r);
      chk("first key", {24'h0, e1}, d);
      rd(ra(8'hF9), d, r);
      chk("second key", {24'h0, e2}, d);
   endtask : kk
   task automatic blkchk(input logic erased);
      for (int i = 0; i < 64; i++)
      begin
         rd(ra(i[7:0]), d, r);
         chk("block byte", {24'h0, erased ? 8'hFF : 8'hC3 ^ i[7:0]}, d);
      end
   endtask : blkchk
   task automatic irq(input logic [4:0] s);
      @(posedge ref_clk);
      irqTake <= 1'b1;
      irqSource <= s;
      @(posedge ref_clk);
      irqTake <= 1'b0;
      @(negedge ref_clk);
   endtask : irq
   task automatic rst();
      @(posedge ref_clk);
      sys_rst <= 1'b1;
      repeat (4) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(negedge ref_clk);
   endtask : rst
   initial
   begin
      repeat (60000) @(posedge ref_clk);
      numErrors++;
      $display("watchdog expired");
      tally_and_finish();
   end
   initial
   begin
      sys_rst = 1'b1;
      axiReq = '0;
      irqTake = 1'b0;
      irqSource = 5'h00;
      rst();
      chk("pc after reset", 32'h0, {16'h0, progCounter});
      for (int i = 0; i < 3; i++)
      begin
         irq(slot[i]);
         chk("vector", {25'h0, slot[i], 2'b00}, {16'h0, progCounter});
      end
      for (int i = 0; i < 3; i++)
      begin
         wr(32'h0000_0008, {16'h0, pcIn[i]}, r);
         rd(32'h0000_0004, d, r);
         chk("user flag", {31'h0, pcIn[i][12:0] >= 13'h0068}, {31'h0, d[4]});
         chk("pc write", {19'h0, pcIn[i][12:0]}, {16'h0, progCounter});
      end
      wr(ra(8'hFF), 32'h0000_01A5, r);
      rd(ra(8'hFF), d, r);
      chk("ram top byte", 32'h0000_00A5, d);
      rd(32'h0000_0014, d, r);
      chk("direct read", 32'h0000_0002, {30'h0, r});
      wr(32'h0000_0014, 32'h0000_0000, r);
      chk("direct write", 32'h0000_0002, {30'h0, r});
      rd(32'h0000_0300, d, r);
      chk("unmapped", 32'h0000_0003, {30'h0, r});
      wr(32'h0000_0010, 32'h0000_8D01, r);
      chk("prot outside isp", 32'h0000_0002, {30'h0, r});
      for (int i = 0; i < 64; i++)
         wr(ra(i[7:0]), {24'h0, 8'hC3 ^ i[7:0]}, r);
      call(`SFCS_FN_WRITE, 8'h05, 8'h3A);
      kk(`SFCS_RC_OK, 8'h00);
      for (int i = 0; i < 64; i++)
         wr(ra(i[7:0]), 32'h0000_0000, r);
      call(`SFCS_FN_READ, 8'h05, 8'h3A);
      blkchk(1'b0);
      call(`SFCS_FN_ERASE, 8'h05, 8'h3A);
      call(`SFCS_FN_READ, 8'h05, 8'h3A);
      blkchk(1'b1);
      call(`SFCS_FN_TABLE, 8'h02, 8'h3A);
      rd(ra(8'hF8), d, r);
      chk("table read", {24'h0, CAL[23:16]}, d);
      u_sfcs_isp_model.pins(1'b1);
      repeat (4) @(negedge ref_clk);
      chk("isp mode", 32'h0000_0001, {31'h0, ispMode});
      // blocks 4..7 get levels 01, 11, 00, 10
      wr(32'h0000_0010, 32'h0000_8D01, r);
      chk("prot write", 32'h0000_0000, {30'h0, r});
      call(`SFCS_FN_WRITE, 8'h05, 8'h3A);
      kk(`SFCS_RC_PROT, 8'h00);
      rd(32'h0000_0000, d, r);
      chk("accumulator", 32'h0000_0000, {24'h0, d[7:0]});
      call(`SFCS_FN_READ, 8'h04, 8'h3A);
      kk(`SFCS_RC_PROT, 8'h00);
      call(`SFCS_FN_ERASE, 8'h07, 8'h3A);
      kk(`SFCS_RC_OK, 8'h00);
      prm(8'h07, 8'h3A);
      u_sfcs_isp_model.issue(`SFCS_FN_ERASE, SP);
      waitc();
      kk(`SFCS_RC_PROT, 8'h00);
      prm(8'h06, 8'h3A);
      u_sfcs_isp_model.issue(`SFCS_FN_ERASE, SP);
      waitc();
      kk(`SFCS_RC_OK, 8'h00);
      prm(8'h00, 8'h3A);
      u_sfcs_isp_model.issue(8'h04, SP);
      waitc();
      kk(`SFCS_RC_FATAL, 8'h00);
      chk("isp undefined halt", 32'h0, {31'h0, cpuHalted});
      u_sfcs_isp_model.pins(1'b0);
      call(`SFCS_FN_ALL, 8'h00, 8'h3A);
      kk(`SFCS_RC_OK, 8'h00);
      call(`SFCS_FN_READ, 8'h04, 8'h3A);
      kk(`SFCS_RC_OK, 8'h00);
      blkchk(1'b1);
      call(`SFCS_FN_TABLE, 8'h02, 8'h3A);
      rd(ra(8'hF8), d, r);
      chk("table after erase", {24'h0, CAL[23:16]}, d);
      call(`SFCS_FN_CSUM, 8'h00, 8'h3A);
      kk(8'hC0, 8'h3F);
      call(`SFCS_FN_READ, 8'h00, 8'h3B);
      chk("bad key halt", 32'h0000_0001, {31'h0, cpuHalted});
      pcHeld = progCounter;
      irq(5'h0D);
      chk("pc frozen", {16'h0, pcHeld}, {16'h0, progCounter});
      rst();
      wr(32'h0000_0008, 32'h0000_0100, r);
      call(`SFCS_FN_BOOT, 8'h00, 8'h3B);
      chk("boot no halt", 32'h0, {31'h0, cpuHalted});
      chk("boot pc", 32'h0, {16'h0, progCounter});
      call(8'h04, 8'h00, 8'h3A);
      chk("undefined halt", 32'h0000_0001, {31'h0, cpuHalted});
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
